// *** common/pcs_pkg.sv ***
// Constants, supply states and control word decoders for the card power switch
`default_nettype none
package pcs_pkg;

    // Serial control word
    localparam int WORD_W = 11;
    localparam int BIT_AUX_A_0 = 0;
    localparam int BIT_AUX_A_1 = 1;
    localparam int BIT_MAIN_A_LO = 2;
    localparam int BIT_MAIN_A_HI = 3;
    localparam int BIT_AUX_B_0 = 4;
    localparam int BIT_AUX_B_1 = 5;
    localparam int BIT_MAIN_B_HI = 6;
    localparam int BIT_MAIN_B_LO = 7;
    localparam int BIT_SHUTDOWN_N = 8;
    localparam int BIT_AUX_A_2 = 9;
    localparam int BIT_AUX_B_2 = 10;
    localparam logic [WORD_W-1:0] WORD_RESET = 11'h000;

    // Parallel select width and fault inputs
    localparam int SEL_W = 4;
    localparam int FAULT_W = 6;

    typedef enum logic [2:0] {
        PCS_SUP_0V,
        PCS_SUP_1V8,
        PCS_SUP_3V3,
        PCS_SUP_5V,
        PCS_SUP_HIZ
    } pcs_supply_e;

    // Auxiliary decode on bits (first, second, third)
    function automatic pcs_supply_e pcs_aux_decode(input logic b0, input logic b1,
                                                   input logic b2);
        pcs_supply_e r;
        r = PCS_SUP_0V;
        case ({b0, b1})
            2'h0: r = PCS_SUP_0V;
            2'h1: r = b2 ? PCS_SUP_5V : PCS_SUP_3V3;
            2'h2: r = PCS_SUP_HIZ;
            default: r = PCS_SUP_1V8;
        endcase
        return r;
    endfunction

    // Main supply decode on (high role, low role) bits
    function automatic pcs_supply_e pcs_main_decode(input logic hi, input logic lo);
        pcs_supply_e r;
        r = PCS_SUP_0V;
        case ({hi, lo})
            2'h1: r = PCS_SUP_3V3;
            2'h2: r = PCS_SUP_5V;
            default: r = PCS_SUP_0V;
        endcase
        return r;
    endfunction

    // Auxiliary selection of the single-socket code
    function automatic pcs_supply_e pcs_single_aux(input logic x, input logic y);
        pcs_supply_e r;
        r = PCS_SUP_0V;
        case ({x, y})
            2'h0: r = PCS_SUP_0V;
            2'h1: r = PCS_SUP_3V3;
            2'h2: r = PCS_SUP_5V;
            default: r = PCS_SUP_1V8;
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire

// *** core/pcs_serial_shift.sv ***
// Serial input shift register running on the link clock
`default_nettype none
module pcs_serial_shift #(
    parameter int WIDTH = pcs_pkg::WORD_W
) (
    // Link
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    // Shifted word
    output logic [WIDTH-1:0] o_shift_word
);
    import pcs_pkg::*;

    logic [WIDTH-1:0] shift_r;

    // First bit sent ends in the top position after a full word
    always_ff @(posedge i_ser_clk) begin
        shift_r <= {shift_r[WIDTH-2:0], i_ser_data};
    end

    assign o_shift_word = shift_r;

endmodule
`default_nettype wire

// *** core/pcs_power_switch.sv ***
// Control logic of the card power switch: serial dual socket and parallel single socket
// Operation
// - Shutdown bit clear makes all four dual-socket outputs high impedance
// - Reset pin low grounds every supply output
// - Dual-socket outputs stay grounded until fresh word latched after reset
// - Latch strobes ignored while reset pin low
// - Shift data bit on each serial clock rise
// - Latch strobe rise loads eleven bits into control
// - Socket A auxiliary decodes bits zero, one, nine
// - Socket B auxiliary decodes bits four, five, ten
// - Socket A main decodes bits three and two
// - Single socket selects main and auxiliary voltages
// - Single socket shutdown codes give high impedance
// - Flag any overcurrent or over temperature condition
// - Flag is open drain, low during fault
// - Parallel shutdown pin forces high impedance
`default_nettype none
module pcs_power_switch (
    // Core clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Serial link from the slot controller
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_ser_latch,
    // Device reset pin
    input wire logic i_reset_n,
    // Parallel single-socket controls
    input wire logic [pcs_pkg::SEL_W-1:0] i_parallel_select,
    input wire logic i_parallel_shutdown_n,
    // Fault sensing: A main, A aux, B main, B aux, single main, single aux
    input wire logic [pcs_pkg::FAULT_W-1:0] i_overcurrent,
    input wire logic i_over_temp,
    // Dual-socket supply states
    output pcs_pkg::pcs_supply_e o_socket_a_main_supply,
    output pcs_pkg::pcs_supply_e o_socket_a_aux_supply,
    output pcs_pkg::pcs_supply_e o_socket_b_main_supply,
    output pcs_pkg::pcs_supply_e o_socket_b_aux_supply,
    // Single-socket supply states
    output pcs_pkg::pcs_supply_e o_single_main_supply,
    output pcs_pkg::pcs_supply_e o_single_aux_supply,
    // Open-drain overcurrent flag
    output logic o_overcurrent_flag_n_out,
    output logic o_overcurrent_flag_n_oe,
    // Active control word and its validity
    output logic [pcs_pkg::WORD_W-1:0] o_control_word,
    output logic o_control_valid
);
    import pcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain

    logic [WORD_W-1:0] shift_word;

    pcs_serial_shift #(
        .WIDTH(WORD_W)
    ) u_shift (
        .i_ser_clk(i_ser_clk),
        .i_ser_data(i_ser_data),
        .o_shift_word(shift_word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, change accepted when stages two and three agree

    localparam int PIN_W = 1 + 1 + SEL_W + 1 + FAULT_W + 1;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [PIN_W-1:0] pin_s3_r;
    logic [PIN_W-1:0] pin_filt_r;

    assign pin_raw = {i_ser_latch, i_reset_n, i_parallel_select, i_parallel_shutdown_n,
                      i_overcurrent, i_over_temp};

    always_ff @(posedge i_core_clk) begin
        pin_s1_r <= pin_raw;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
    end

    // Idle values: latch low, reset released, selects zero, shutdown off, no fault
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b0, 1'b1, {SEL_W{1'b0}}, 1'b1,
                                             {FAULT_W{1'b0}}, 1'b0};

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pin_filt_r <= PIN_IDLE;
        end else begin
            for (int i = 0; i < PIN_W; i++) begin
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_filt_r[i] <= pin_s3_r[i];
                end
            end
        end
    end

    logic latch_f;
    logic reset_n_f;
    logic [SEL_W-1:0] select_f;
    logic shutdown_n_f;
    logic [FAULT_W-1:0] overcurrent_f;
    logic over_temp_f;

    assign {latch_f, reset_n_f, select_f, shutdown_n_f, overcurrent_f, over_temp_f} =
        pin_filt_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Shift word capture into the core domain
    // The word is static while the strobe is high, since the link clock waits for it

    logic [WORD_W-1:0] word_s1_r;
    logic [WORD_W-1:0] word_s2_r;

    always_ff @(posedge i_core_clk) begin
        word_s1_r <= shift_word;
        word_s2_r <= word_s1_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latch strobe edge

    logic latch_prev_r;
    logic latch_rise;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            latch_prev_r <= 1'b0;
        end else begin
            latch_prev_r <= latch_f;
        end
    end

    assign latch_rise = latch_f & ~latch_prev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Load sequencing
    // A strobe whose word is still settling in the capture stages waits for them to agree

    typedef enum logic {
        PCS_LOAD_IDLE,
        PCS_LOAD_WAIT
    } pcs_load_e;

    pcs_load_e load_state_r;
    logic word_agree;
    logic load_now;

    assign word_agree = (word_s1_r == word_s2_r);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            load_state_r <= PCS_LOAD_IDLE;
        end else begin
            case (load_state_r)
                PCS_LOAD_IDLE: begin
                    if (latch_rise && reset_n_f && !word_agree) begin
                        load_state_r <= PCS_LOAD_WAIT;
                    end
                end
                PCS_LOAD_WAIT: begin
                    if (!reset_n_f || word_agree) begin
                        load_state_r <= PCS_LOAD_IDLE;
                    end
                end
                default: begin
                    load_state_r <= PCS_LOAD_IDLE;
                end
            endcase
        end
    end

    // Strobes are dropped while the reset pin is low
    assign load_now = reset_n_f && word_agree && (latch_rise || load_state_r == PCS_LOAD_WAIT);

    ////////////////////////////////////////////////////////////////////////////////
    // Active control word

    logic [WORD_W-1:0] ctrl_word_r;
    logic ctrl_valid_r;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_word_r <= WORD_RESET;
        end else if (load_now) begin
            ctrl_word_r <= word_s2_r;
        end
    end

    // Cleared by the reset pin, set by the first strobe after its release
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl_valid_r <= 1'b0;
        end else if (!reset_n_f) begin
            ctrl_valid_r <= 1'b0;
        end else if (load_now) begin
            ctrl_valid_r <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_control_word <= WORD_RESET;
            o_control_valid <= 1'b0;
        end else begin
            o_control_word <= ctrl_word_r;
            o_control_valid <= ctrl_valid_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dual-socket decode

    pcs_supply_e a_main_nxt;
    pcs_supply_e a_aux_nxt;
    pcs_supply_e b_main_nxt;
    pcs_supply_e b_aux_nxt;

    always_comb begin
        a_main_nxt = PCS_SUP_0V;
        a_aux_nxt = PCS_SUP_0V;
        b_main_nxt = PCS_SUP_0V;
        b_aux_nxt = PCS_SUP_0V;
        if (!reset_n_f || !ctrl_valid_r) begin
            a_main_nxt = PCS_SUP_0V;
            a_aux_nxt = PCS_SUP_0V;
            b_main_nxt = PCS_SUP_0V;
            b_aux_nxt = PCS_SUP_0V;
        end else if (!ctrl_word_r[BIT_SHUTDOWN_N]) begin
            a_main_nxt = PCS_SUP_HIZ;
            a_aux_nxt = PCS_SUP_HIZ;
            b_main_nxt = PCS_SUP_HIZ;
            b_aux_nxt = PCS_SUP_HIZ;
        end else begin
            a_aux_nxt = pcs_aux_decode(ctrl_word_r[BIT_AUX_A_0], ctrl_word_r[BIT_AUX_A_1],
                                       ctrl_word_r[BIT_AUX_A_2]);
            b_aux_nxt = pcs_aux_decode(ctrl_word_r[BIT_AUX_B_0], ctrl_word_r[BIT_AUX_B_1],
                                       ctrl_word_r[BIT_AUX_B_2]);
            a_main_nxt = pcs_main_decode(ctrl_word_r[BIT_MAIN_A_HI],
                                         ctrl_word_r[BIT_MAIN_A_LO]);
            b_main_nxt = pcs_main_decode(ctrl_word_r[BIT_MAIN_B_HI],
                                         ctrl_word_r[BIT_MAIN_B_LO]);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_socket_a_main_supply <= PCS_SUP_0V;
            o_socket_a_aux_supply <= PCS_SUP_0V;
            o_socket_b_main_supply <= PCS_SUP_0V;
            o_socket_b_aux_supply <= PCS_SUP_0V;
        end else begin
            o_socket_a_main_supply <= a_main_nxt;
            o_socket_a_aux_supply <= a_aux_nxt;
            o_socket_b_main_supply <= b_main_nxt;
            o_socket_b_aux_supply <= b_aux_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Single-socket decode, selects read continuously with no latch

    pcs_supply_e s_main_nxt;
    pcs_supply_e s_aux_nxt;
    logic sel_d0;
    logic sel_d1;
    logic sel_d2;
    logic sel_d3;

    assign sel_d0 = select_f[0];
    assign sel_d1 = select_f[1];
    assign sel_d2 = select_f[2];
    assign sel_d3 = select_f[3];

    always_comb begin
        s_main_nxt = PCS_SUP_0V;
        s_aux_nxt = PCS_SUP_0V;
        if (!reset_n_f) begin
            s_main_nxt = PCS_SUP_0V;
            s_aux_nxt = PCS_SUP_0V;
        end else if (!shutdown_n_f) begin
            s_main_nxt = PCS_SUP_HIZ;
            s_aux_nxt = PCS_SUP_HIZ;
        end else begin
            case ({sel_d0, sel_d1})
                2'h0: begin
                    if (sel_d2 || sel_d3) begin
                        s_main_nxt = PCS_SUP_HIZ;
                        s_aux_nxt = PCS_SUP_HIZ;
                    end else begin
                        s_main_nxt = PCS_SUP_0V;
                        s_aux_nxt = PCS_SUP_0V;
                    end
                end
                2'h1: begin
                    s_main_nxt = PCS_SUP_3V3;
                    s_aux_nxt = pcs_single_aux(sel_d2, sel_d3);
                end
                2'h2: begin
                    s_main_nxt = PCS_SUP_5V;
                    s_aux_nxt = pcs_single_aux(sel_d2, sel_d3);
                end
                default: begin
                    s_aux_nxt = PCS_SUP_HIZ;
                    case ({sel_d2, sel_d3})
                        2'h1: s_main_nxt = PCS_SUP_3V3;
                        2'h2: s_main_nxt = PCS_SUP_5V;
                        default: s_main_nxt = PCS_SUP_HIZ;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_single_main_supply <= PCS_SUP_0V;
            o_single_aux_supply <= PCS_SUP_0V;
        end else begin
            o_single_main_supply <= s_main_nxt;
            o_single_aux_supply <= s_aux_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Overcurrent flag, pulled low while any fault stands

    logic fault_any;

    assign fault_any = (|overcurrent_f) | over_temp_f;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_overcurrent_flag_n_out <= 1'b0;
            o_overcurrent_flag_n_oe <= 1'b0;
        end else begin
            o_overcurrent_flag_n_out <= 1'b0;
            o_overcurrent_flag_n_oe <= fault_any;
        end
    end

endmodule
`default_nettype wire

// *** tb/pcs_power_switch_props.sv ***
// Assertions on the card power switch ports
`default_nettype none
module pcs_power_switch_props import pcs_pkg::*; (
    // Clock, reset and pins
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ser_latch,
    input wire logic i_reset_n,
    input wire logic [pcs_pkg::SEL_W-1:0] i_parallel_select,
    input wire logic i_parallel_shutdown_n,
    input wire logic [pcs_pkg::FAULT_W-1:0] i_overcurrent,
    input wire logic i_over_temp,
    // Switch outputs
    input var pcs_pkg::pcs_supply_e o_socket_a_main_supply,
    input var pcs_pkg::pcs_supply_e o_socket_a_aux_supply,
    input var pcs_pkg::pcs_supply_e o_socket_b_main_supply,
    input var pcs_pkg::pcs_supply_e o_socket_b_aux_supply,
    input var pcs_pkg::pcs_supply_e o_single_main_supply,
    input var pcs_pkg::pcs_supply_e o_single_aux_supply,
    input wire logic o_overcurrent_flag_n_out,
    input wire logic o_overcurrent_flag_n_oe,
    input wire logic [pcs_pkg::WORD_W-1:0] o_control_word,
    input wire logic o_control_valid
);
    function automatic pcs_supply_e f_main(logic hi, logic lo);
        return (hi == lo) ? PCS_SUP_0V : (hi ? PCS_SUP_5V : PCS_SUP_3V3);
    endfunction
    function automatic pcs_supply_e f_aux(logic b0, logic b1, logic b2);
        return !b0 ? (!b1 ? PCS_SUP_0V : (b2 ? PCS_SUP_5V : PCS_SUP_3V3))
            : (!b1 ? PCS_SUP_HIZ : PCS_SUP_1V8);
    endfunction
    function automatic logic [5:0] f_single(logic [3:0] c);
        pcs_supply_e m;
        pcs_supply_e a;
        a = pcs_supply_e'({1'b0, c[2] ^ c[3], c[2]});
        m = c[0] ? PCS_SUP_5V : PCS_SUP_3V3;
        if (c[0] == c[1]) begin
            m = (c[3:2] == 2'h0 && !c[0]) ? PCS_SUP_0V : PCS_SUP_HIZ;
            a = m;
            if (c[0] && c[2] != c[3]) begin
                m = c[2] ? PCS_SUP_5V : PCS_SUP_3V3;
            end
        end
        return {m, a};
    endfunction
    ////////////////////////////////////////
    // Word settled for eight cycles with the reset pin released
    logic [WORD_W-1:0] word_q_r;
    logic [3:0] calm_r;
    wire logic calm = calm_r == 4'h8 && o_control_word == word_q_r;
    wire logic live = calm && o_control_word[BIT_SHUTDOWN_N];
    wire logic [10:0] w = o_control_word;
    wire logic fault = |i_overcurrent || i_over_temp;
    always_ff @(posedge i_core_clk) begin
        word_q_r <= o_control_word;
        if (i_rst || !i_reset_n || !o_control_valid || o_control_word != word_q_r) begin
            calm_r <= 4'h0;
        end else if (calm_r != 4'h8) begin
            calm_r <= calm_r + 4'h1;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_hiz;
        calm && !w[BIT_SHUTDOWN_N] |-> $past(o_socket_a_main_supply) == PCS_SUP_HIZ
            && $past(o_socket_b_aux_supply) == PCS_SUP_HIZ;
    endproperty
    a_hiz: assert property (p_hiz) else $error("outputs not high impedance");
    property p_gnd;
        !i_reset_n [*7] |-> o_socket_a_main_supply == PCS_SUP_0V
            && o_socket_b_aux_supply == PCS_SUP_0V && o_single_main_supply == PCS_SUP_0V;
    endproperty
    a_gnd: assert property (p_gnd) else $error("outputs not grounded");
    property p_fresh;
        !$past(o_control_valid) && !o_control_valid
            |-> $past(o_socket_b_main_supply) == PCS_SUP_0V;
    endproperty
    a_fresh: assert property (p_fresh) else $error("output before fresh word");
    property p_aux_a;
        live |-> $past(o_socket_a_aux_supply) == f_aux(w[0], w[1], w[9]);
    endproperty
    a_aux_a: assert property (p_aux_a) else $error("socket a aux decode");
    property p_aux_b;
        live |-> $past(o_socket_b_aux_supply) == f_aux(w[4], w[5], w[10]);
    endproperty
    a_aux_b: assert property (p_aux_b) else $error("socket b aux decode");
    property p_main_a;
        live |-> $past(o_socket_a_main_supply) == f_main(w[3], w[2]);
    endproperty
    a_main_a: assert property (p_main_a) else $error("socket a main decode");
    property p_main_b;
        live |-> $past(o_socket_b_main_supply) == f_main(w[6], w[7]);
    endproperty
    a_main_b: assert property (p_main_b) else $error("socket b main decode");
    property p_single;
        (i_parallel_shutdown_n && i_reset_n && $stable(i_parallel_select)) [*8]
            |-> {o_single_main_supply, o_single_aux_supply} == f_single(i_parallel_select);
    endproperty
    a_single: assert property (p_single) else $error("single decode");
    property p_single_off;
        (!i_parallel_shutdown_n && i_reset_n) [*7] |-> o_single_main_supply == PCS_SUP_HIZ
            && o_single_aux_supply == PCS_SUP_HIZ;
    endproperty
    a_single_off: assert property (p_single_off) else $error("shutdown pin ignored");
    property p_flag;
        $stable(fault) [*6] |-> o_overcurrent_flag_n_oe == fault && !o_overcurrent_flag_n_out;
    endproperty
    a_flag: assert property (p_flag) else $error("flag wrong");
    property p_hold;
        (!i_ser_latch && i_reset_n) [*8] |-> $stable(o_control_word);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed without latch");
    c_valid: cover property ($rose(o_control_valid));
    c_shdn: cover property (calm && !w[BIT_SHUTDOWN_N]);
    c_flag: cover property ($rose(o_overcurrent_flag_n_oe));
endmodule
bind pcs_power_switch pcs_power_switch_props i_props (.i_core_clk, .i_rst, .i_ser_latch,
    .i_reset_n, .i_parallel_select, .i_parallel_shutdown_n, .i_overcurrent, .i_over_temp,
    .o_socket_a_main_supply, .o_socket_a_aux_supply, .o_socket_b_main_supply,
    .o_socket_b_aux_supply, .o_single_main_supply, .o_single_aux_supply,
    .o_overcurrent_flag_n_out, .o_overcurrent_flag_n_oe, .o_control_word, .o_control_valid);
`default_nettype wire

// *** tb/pcs_ser_ctrl_model.sv ***
// Slot controller model driving the serial link
`default_nettype none
module pcs_ser_ctrl_model (
    // Serial link
    output logic o_ser_clk,
    output logic o_ser_data,
    output logic o_ser_latch
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_ser_latch = 1'b0;
    end
    // Link clock runs only inside a frame; data line flips once released
    task automatic frame(input logic [10:0] word, input bit do_latch);
        for (int i = 10; i >= 0; i--) begin
            o_ser_data = word[i];
            #12 o_ser_clk = 1'b1;
            #24 o_ser_clk = 1'b0;
            #12;
        end
        o_ser_data = ~word[0];
        if (do_latch) begin
            o_ser_latch = 1'b1;
            #100 o_ser_latch = 1'b0;
        end
        #100;
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the card power switch
`default_nettype none
module testbench import pcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_reset_n = 1'b1;
    logic i_parallel_shutdown_n = 1'b1;
    logic i_over_temp = 1'b0;
    logic [SEL_W-1:0] i_parallel_select = 4'h0;
    logic [FAULT_W-1:0] i_overcurrent = 6'h00;
    logic i_ser_clk, i_ser_data, i_ser_latch;
    logic o_overcurrent_flag_n_out, o_overcurrent_flag_n_oe, o_control_valid;
    logic [WORD_W-1:0] o_control_word;
    pcs_supply_e o_socket_a_main_supply, o_socket_a_aux_supply, o_socket_b_main_supply;
    pcs_supply_e o_socket_b_aux_supply, o_single_main_supply, o_single_aux_supply;
    wire logic flag_n = o_overcurrent_flag_n_oe ? o_overcurrent_flag_n_out : 1'b1;
    int failures = 0;
    int n_compared = 0;
    logic [10:0] words [5] = '{11'h156, 11'h3BA, 11'h7EF, 11'h501, 11'h6FF};
    pcs_supply_e exp_dual [5][4] = '{'{PCS_SUP_3V3, PCS_SUP_3V3, PCS_SUP_5V, PCS_SUP_HIZ},
        '{PCS_SUP_5V, PCS_SUP_5V, PCS_SUP_3V3, PCS_SUP_1V8},
        '{PCS_SUP_0V, PCS_SUP_1V8, PCS_SUP_0V, PCS_SUP_5V},
        '{PCS_SUP_0V, PCS_SUP_HIZ, PCS_SUP_0V, PCS_SUP_0V},
        '{PCS_SUP_HIZ, PCS_SUP_HIZ, PCS_SUP_HIZ, PCS_SUP_HIZ}};
    pcs_supply_e exp_single [16][2] = '{'{PCS_SUP_0V, PCS_SUP_0V}, '{PCS_SUP_5V, PCS_SUP_0V},
        '{PCS_SUP_3V3, PCS_SUP_0V}, '{PCS_SUP_HIZ, PCS_SUP_HIZ}, '{PCS_SUP_HIZ, PCS_SUP_HIZ},
        '{PCS_SUP_5V, PCS_SUP_5V}, '{PCS_SUP_3V3, PCS_SUP_5V}, '{PCS_SUP_5V, PCS_SUP_HIZ},
        '{PCS_SUP_HIZ, PCS_SUP_HIZ}, '{PCS_SUP_5V, PCS_SUP_3V3}, '{PCS_SUP_3V3, PCS_SUP_3V3},
        '{PCS_SUP_3V3, PCS_SUP_HIZ}, '{PCS_SUP_HIZ, PCS_SUP_HIZ}, '{PCS_SUP_5V, PCS_SUP_1V8},
        '{PCS_SUP_3V3, PCS_SUP_1V8}, '{PCS_SUP_HIZ, PCS_SUP_HIZ}};
    always #5 i_core_clk = ~i_core_clk;
    pcs_power_switch i_dut (.i_core_clk, .i_rst, .i_ser_clk, .i_ser_data, .i_ser_latch,
        .i_reset_n, .i_parallel_select, .i_parallel_shutdown_n, .i_overcurrent, .i_over_temp,
        .o_socket_a_main_supply, .o_socket_a_aux_supply, .o_socket_b_main_supply,
        .o_socket_b_aux_supply, .o_single_main_supply, .o_single_aux_supply,
        .o_overcurrent_flag_n_out, .o_overcurrent_flag_n_oe, .o_control_word, .o_control_valid);
    pcs_ser_ctrl_model i_ctrl (.o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
        .o_ser_latch(i_ser_latch));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic chk_dual(input pcs_supply_e am, aa, bm, ba);
        chk("a_main", 11'(am), 11'(o_socket_a_main_supply));
        chk("a_aux", 11'(aa), 11'(o_socket_a_aux_supply));
        chk("b_main", 11'(bm), 11'(o_socket_b_main_supply));
        chk("b_aux", 11'(ba), 11'(o_socket_b_aux_supply));
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        pcs_supply_e d [4];
        tick(2);
        i_rst = 1'b0;
        i_reset_n = 1'b0;
        tick(6);
        chk_dual(PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V);
        i_ctrl.frame(11'h156, 1'b1);
        tick(2);
        i_reset_n = 1'b1;
        tick(8);
        chk("valid", 11'h000, 11'(o_control_valid));
        chk("word", WORD_RESET, o_control_word);
        chk_dual(PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V);
        for (int k = 0; k < 5; k++) begin
            i_ctrl.frame(words[k], 1'b1);
            tick(10);
            chk("word", words[k], o_control_word);
            d = exp_dual[k];
            chk_dual(d[0], d[1], d[2], d[3]);
        end
        i_ctrl.frame(11'h3BA, 1'b0);
        tick(10);
        chk("word", 11'h6FF, o_control_word);
        i_reset_n = 1'b0;
        tick(8);
        chk_dual(PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V);
        chk("single", 11'(PCS_SUP_0V), 11'(o_single_main_supply));
        i_reset_n = 1'b1;
        tick(8);
        chk_dual(PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V, PCS_SUP_0V);
        for (int c = 0; c < 16; c++) begin
            i_parallel_select = 4'(c);
            tick(9);
            chk("single_main", 11'(exp_single[c][0]), 11'(o_single_main_supply));
            chk("single_aux", 11'(exp_single[c][1]), 11'(o_single_aux_supply));
        end
        i_parallel_select = 4'h6;
        tick(8);
        chk("single_main", 11'(PCS_SUP_3V3), 11'(o_single_main_supply));
        chk("single_aux", 11'(PCS_SUP_5V), 11'(o_single_aux_supply));
        i_parallel_shutdown_n = 1'b0;
        tick(8);
        chk("single_off", 11'(PCS_SUP_HIZ), 11'(o_single_aux_supply));
        i_parallel_shutdown_n = 1'b1;
        for (int f = 0; f < FAULT_W + 1; f++) begin
            {i_over_temp, i_overcurrent} = 7'h01 << f;
            tick(8);
            chk("flag", 11'h000, 11'(flag_n));
            {i_over_temp, i_overcurrent} = 7'h00;
            tick(8);
            chk("flag", 11'h001, 11'(flag_n));
        end
        end_of_test();
    end
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
